/* File: logic/bms_lane_swap.sv */
// Purpose: Registered byte-lane reorder for data in the selected byte order
// Assumes: Data is presented little-endian on the lanes
// Notes:   Fetches pass unswapped
`timescale 1ns/10ps
module bms_lane_swap
    import bms_pkg::*;
#(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Data in
    input  wire logic [W-1:0] din,
    input  wire logic [1:0]   size,
    input  wire logic         big,
    // Data out
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] data;
    } bms_swap_state_t;

    bms_swap_state_t st;
    bms_swap_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.data = din;
        if (big) begin
            if (size == BMS_SZ_WORD) begin
                for (int i = 0; i < W / 8; i++) begin
                    next_st.data[i*8 +: 8] = din[(W/8-1-i)*8 +: 8];
                end
            end else if (size == BMS_SZ_HALF) begin
                next_st.data[15:0] = {din[7:0], din[15:8]};
            end
        end
        if (sys_rst) begin
            next_st.data = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign dout = st.data;

endmodule

/* File: logic/bms_mode_ctrl.sv */
// Purpose: Reset-time mode selection, system control bits, access gating
// Assumes: Straps are stable and synchronous to clk around reset
// Notes:   Straps are captured on every rising edge while sys_rst is high
`timescale 1ns/10ps
module bms_mode_ctrl
    import bms_pkg::*;
#(
    parameter bit          HAS_USER_BOOT = 1'b1,
    parameter int unsigned DW            = 32
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // Strap pins
    input  wire logic          mode_pin_a,
    input  wire logic          mode_pin_b,
    input  wire logic          endian_select_pin,
    // System control write
    input  wire logic          ctl_wr,
    input  wire logic          ctl_wr_rom_enable,
    input  wire logic          ctl_wr_ext_bus_enable,
    // Memory access check
    input  wire logic          acc_valid,
    input  wire logic [31:0]   acc_addr,
    input  wire logic          acc_fetch,
    input  wire logic [1:0]    acc_size,
    input  wire logic [DW-1:0] acc_rdata,
    // Status and control outputs
    output logic      [2:0]    mode_pin_status,
    output logic      [1:0]    boot_mode,
    output logic               onchip_rom_enable,
    output logic               external_bus_enable,
    output logic               big_endian,
    // Start of execution
    output logic               start_pulse,
    output logic               start_indirect,
    output logic      [31:0]   start_addr,
    // Access answer
    output logic               acc_grant,
    output logic               acc_deny,
    output logic      [DW-1:0] acc_data
);

    typedef struct packed {
        logic [2:0]  straps;
        bms_mode_t   mode;
        logic        rom_en;
        logic        ext_en;
        logic        started;
        logic        start_pulse;
        logic        start_ind;
        logic [31:0] start_addr;
        logic        grant;
        logic        deny;
    } bms_state_t;

    bms_state_t st;
    bms_state_t next_st;

    logic in_loader;
    logic in_uboot;
    logic in_rom;
    logic in_ext;
    logic blocked;

    ////////////////////////////////////////////////////////////////////////////
    // Address classification

    always_comb begin
        in_loader = (acc_addr >= BMS_LDR_BASE) && (acc_addr < BMS_LDR_BASE + BMS_LDR_SIZE);
        in_uboot  = HAS_USER_BOOT && (acc_addr >= BMS_UBOOT_BASE)
                    && (acc_addr < BMS_UBOOT_BASE + BMS_UBOOT_SIZE);
        in_rom    = (acc_addr >= BMS_ROM_BASE) && !in_loader;
        in_ext    = (acc_addr >= BMS_EXT_BASE) && (acc_addr < BMS_EXT_LIMIT);
        blocked   = in_loader
                  | ((in_rom | in_uboot) & ~st.rom_en)
                  | (in_ext & ~st.ext_en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.start_pulse = 1'b0;
        next_st.grant = acc_valid & ~blocked;
        next_st.deny  = acc_valid & blocked;
        if (!st.started) begin
            next_st.started     = 1'b1;
            next_st.start_pulse = 1'b1;
            case (st.mode)
                BMS_MODE_SERIAL: begin
                    next_st.start_ind  = 1'b0;
                    next_st.start_addr = BMS_SERIAL_ENTRY;
                end
                BMS_MODE_UBOOT: begin
                    if (HAS_USER_BOOT) begin
                        next_st.start_ind  = 1'b1;
                        next_st.start_addr = BMS_UBOOT_VECTOR;
                    end else begin
                        next_st.start_ind  = 1'b0;
                        next_st.start_addr = BMS_USB_ENTRY;
                    end
                end
                BMS_MODE_SINGLE: begin
                    next_st.start_ind  = 1'b1;
                    next_st.start_addr = BMS_RESET_VECTOR;
                end
                default: begin
                    next_st.started     = 1'b0;
                    next_st.start_pulse = 1'b0;
                end
            endcase
        end
        if (ctl_wr) begin
            next_st.rom_en = st.rom_en & ctl_wr_rom_enable;
            next_st.ext_en = ctl_wr_ext_bus_enable;
        end
        if (sys_rst) begin
            next_st.straps[BMS_STAT_A]   = mode_pin_a;
            next_st.straps[BMS_STAT_B]   = mode_pin_b;
            next_st.straps[BMS_STAT_END] = endian_select_pin;
            next_st.mode        = bms_mode_t'({mode_pin_b, mode_pin_a});
            next_st.rom_en      = BMS_ROM_EN_RST;
            next_st.ext_en      = BMS_EXT_EN_RST;
            next_st.started     = 1'b0;
            next_st.start_pulse = 1'b0;
            next_st.start_ind   = 1'b0;
            next_st.start_addr  = '0;
            next_st.grant       = 1'b0;
            next_st.deny        = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte lanes

    bms_lane_swap #(
        .W       (DW)
    ) u_swap (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (acc_rdata),
        .size    (acc_size),
        .big     (st.straps[BMS_STAT_END] & ~acc_fetch),
        .dout    (acc_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mode_pin_status     = st.straps;
    assign boot_mode           = st.mode;
    assign onchip_rom_enable   = st.rom_en;
    assign external_bus_enable = st.ext_en;
    assign big_endian          = st.straps[BMS_STAT_END];
    assign start_pulse         = st.start_pulse;
    assign start_indirect      = st.start_ind;
    assign start_addr          = st.start_addr;
    assign acc_grant           = st.grant;
    assign acc_deny            = st.deny;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    strap_capture_a: assert property ($fell(sys_rst) |->
        mode_pin_status == $past({endian_select_pin, mode_pin_b, mode_pin_a}, 2))
        else $error("strap status differs from pins at reset release");

    serial_start_a: assert property (start_pulse && boot_mode == BMS_MODE_SERIAL |->
        !start_indirect && start_addr == BMS_SERIAL_ENTRY)
        else $error("serial boot start wrong");

    uboot_vec_a: assert property (start_pulse && boot_mode == BMS_MODE_UBOOT |->
        (HAS_USER_BOOT ? (start_indirect && start_addr == BMS_UBOOT_VECTOR)
                       : (!start_indirect && start_addr == BMS_USB_ENTRY)))
        else $error("user boot or usb start wrong");

    single_vec_a: assert property (start_pulse && boot_mode == BMS_MODE_SINGLE |->
        start_indirect && start_addr == BMS_RESET_VECTOR)
        else $error("single-chip vector wrong");

    start_once_a: assert property ($fell(sys_rst) && boot_mode != BMS_MODE_NONE |->
        ##1 start_pulse ##1 !start_pulse [*8])
        else $error("start pulse not single");

    loader_lock_a: assert property (acc_valid && in_loader |=> acc_deny && !acc_grant)
        else $error("loader area access not denied");

    rom_off_a: assert property (acc_valid && (in_rom || in_uboot) && !onchip_rom_enable
        |=> acc_deny)
        else $error("flash reached with rom disabled");

    ext_gate_a: assert property (acc_valid && in_ext && !in_loader |=>
        acc_grant == $past(external_bus_enable))
        else $error("external bus gating wrong");

    reset_vals_a: assert property ($fell(sys_rst) |-> onchip_rom_enable && !external_bus_enable)
        else $error("control bits wrong after reset");

    rom_sticky_a: assert property (!onchip_rom_enable |=> !onchip_rom_enable)
        else $error("rom enable came back");

    fetch_little_a: assert property (acc_fetch |=> acc_data == $past(acc_rdata))
        else $error("fetch data was reordered");

    big_word_a: assert property (!acc_fetch && big_endian && acc_size == BMS_SZ_WORD |=>
        acc_data[7:0] == $past(acc_rdata[DW-1:DW-8]))
        else $error("big-endian word lanes wrong");

    cov_serial: cover property (start_pulse && boot_mode == BMS_MODE_SERIAL);
    cov_single: cover property (start_pulse && boot_mode == BMS_MODE_SINGLE);
    cov_rom_off: cover property ($fell(onchip_rom_enable) ##1 ctl_wr && ctl_wr_rom_enable);
    cov_ext_on: cover property ($rose(external_bus_enable) && onchip_rom_enable);

endmodule

/* File: shared/bms_pkg.sv */
// Purpose: Shared constants for the boot mode and memory map select block
// Assumes: 125 MHz system clock, synchronous active-high reset
// Notes:   Addresses and region sizes are fixed here so that every file agrees
package bms_pkg;

    typedef enum logic [1:0] {
        BMS_MODE_NONE   = 2'b00,
        BMS_MODE_SERIAL = 2'b01,
        BMS_MODE_UBOOT  = 2'b10,
        BMS_MODE_SINGLE = 2'b11
    } bms_mode_t;

    // Strap status bit positions
    localparam int unsigned BMS_STAT_A   = 0;
    localparam int unsigned BMS_STAT_B   = 1;
    localparam int unsigned BMS_STAT_END = 2;

    // Reset values of the system control bits
    localparam logic BMS_ROM_EN_RST = 1'b1;
    localparam logic BMS_EXT_EN_RST = 1'b0;

    // Vector locations
    localparam logic [31:0] BMS_UBOOT_VECTOR = 32'hFF7FFFFC;
    localparam logic [31:0] BMS_RESET_VECTOR = 32'h0FFFFFFC;

    // Memory regions
    localparam logic [31:0] BMS_ROM_BASE    = 32'hFF000000;
    localparam logic [31:0] BMS_UBOOT_BASE  = 32'hFF7FC000;
    localparam logic [31:0] BMS_UBOOT_SIZE  = 32'h00004000;
    localparam logic [31:0] BMS_LDR_BASE    = 32'hFF7F0000;
    localparam logic [31:0] BMS_LDR_SIZE    = 32'h00008000;
    localparam logic [31:0] BMS_SERIAL_ENTRY = 32'hFF7F0000;
    localparam logic [31:0] BMS_USB_ENTRY    = 32'hFF7F4000;
    localparam logic [31:0] BMS_EXT_BASE    = 32'h01000000;
    localparam logic [31:0] BMS_EXT_LIMIT   = 32'h08000000;

    // Access sizes
    localparam logic [1:0] BMS_SZ_BYTE = 2'h0;
    localparam logic [1:0] BMS_SZ_HALF = 2'h1;
    localparam logic [1:0] BMS_SZ_WORD = 2'h2;

endpackage

/* File: sim/bms_board_model.sv */
// Purpose: Board strap model: mode and endian straps seen by the chip
// Assumes: Straps may only move while the chip is held in reset
// Notes:   Requested levels are applied on the falling edge
`timescale 1ns/10ps
module bms_board_model
    import bms_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Requested straps
    input  wire logic [1:0] want_mode,
    input  wire logic       want_big,
    // Strap pins
    output logic            mode_pin_a,
    output logic            mode_pin_b,
    output logic            endian_select_pin
);
    initial begin
        {mode_pin_b, mode_pin_a} = 2'h3;
        endian_select_pin = 1'b0;
    end
    // Straps are frozen while the chip runs
    always @(negedge clk) begin
        if (sys_rst) begin
            {mode_pin_b, mode_pin_a} <= want_mode;
            endian_select_pin        <= want_big;
        end
    end
endmodule

/* File: sim/boot_mode_and_memory_map_select_tb.sv */
// Purpose: Self-checking bench for the mode and memory map select block
// Assumes: Inputs change on the falling edge, outputs read there too
// Notes:   Each scenario starts from a fresh strap reset where needed
`timescale 1ns/10ps
module boot_mode_and_memory_map_select_tb
    import bms_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, big = 1'b0;
    logic [1:0] mode = 2'h3;
    logic pa, pb, pe, ctl_wr = 1'b0, wr_rom = 1'b1, wr_ext = 1'b0;
    logic acc_valid = 1'b0, acc_fetch = 1'b0;
    logic [31:0] acc_addr = 32'h0, acc_rdata = 32'h0;
    logic [1:0] acc_size = 2'h0;
    logic [2:0] stat;
    logic [1:0] bmode;
    logic rom_en, ext_en, big_o, s_pulse, s_ind, grant, deny;
    logic [31:0] s_addr, acc_data;
    logic u_pulse, u_ind;
    logic [31:0] u_addr;
    int err_count = 0, n_tests = 0, cycles = 0;

    always #4 clk = ~clk;

    bms_board_model brd (.clk(clk), .sys_rst(sys_rst), .want_mode(mode), .want_big(big),
        .mode_pin_a(pa), .mode_pin_b(pb), .endian_select_pin(pe));

    bms_mode_ctrl #(.HAS_USER_BOOT(1'b1), .DW(32)) uut (.clk(clk), .sys_rst(sys_rst),
        .mode_pin_a(pa), .mode_pin_b(pb), .endian_select_pin(pe), .ctl_wr(ctl_wr),
        .ctl_wr_rom_enable(wr_rom), .ctl_wr_ext_bus_enable(wr_ext),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_fetch(acc_fetch),
        .acc_size(acc_size), .acc_rdata(acc_rdata), .mode_pin_status(stat),
        .boot_mode(bmode), .onchip_rom_enable(rom_en), .external_bus_enable(ext_en),
        .big_endian(big_o), .start_pulse(s_pulse), .start_indirect(s_ind),
        .start_addr(s_addr), .acc_grant(grant), .acc_deny(deny), .acc_data(acc_data));

    // Variant without a user boot area, seeing the same straps
    bms_mode_ctrl #(.HAS_USER_BOOT(1'b0), .DW(32)) uut_usb (.clk(clk), .sys_rst(sys_rst),
        .mode_pin_a(pa), .mode_pin_b(pb), .endian_select_pin(pe), .ctl_wr(ctl_wr),
        .ctl_wr_rom_enable(wr_rom), .ctl_wr_ext_bus_enable(wr_ext),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_fetch(acc_fetch),
        .acc_size(acc_size), .acc_rdata(acc_rdata), .mode_pin_status(),
        .boot_mode(), .onchip_rom_enable(), .external_bus_enable(),
        .big_endian(), .start_pulse(u_pulse), .start_indirect(u_ind),
        .start_addr(u_addr), .acc_grant(), .acc_deny(), .acc_data());

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic boot(input logic [1:0] m, input logic b, input logic pls,
                        input logic ind, input logic [31:0] adr);
        mode = m;
        big = b;
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk("status", {29'h0, b, m}, {29'h0, stat});
        chk("mode", {30'h0, m}, {30'h0, bmode});
        chk("endian", {31'h0, b}, {31'h0, big_o});
        chk("rom_rst", 32'h1, {31'h0, rom_en});
        chk("ext_rst", 32'h0, {31'h0, ext_en});
        chk("pulse", {31'h0, pls}, {31'h0, s_pulse});
        if (pls) begin
            chk("indirect", {31'h0, ind}, {31'h0, s_ind});
            chk("start", adr, s_addr);
            if (m == 2'h2) begin
                chk("usb_pulse", 32'h1, {31'h0, u_pulse});
                chk("usb_indirect", 32'h0, {31'h0, u_ind});
                chk("usb_start", BMS_USB_ENTRY, u_addr);
            end
        end
        @(negedge clk);
        chk("pulse_end", 32'h0, {31'h0, s_pulse});
    endtask

    task automatic access(input logic [31:0] a, input logic f, input logic ok);
        acc_valid = 1'b1;
        acc_addr = a;
        acc_fetch = f;
        @(negedge clk);
        acc_valid = 1'b0;
        chk("grant", {31'h0, ok}, {31'h0, grant});
        chk("deny", {31'h0, !ok}, {31'h0, deny});
        @(negedge clk);
        chk("grant_end", 32'h0, {31'h0, grant});
        chk("deny_end", 32'h0, {31'h0, deny});
    endtask

    task automatic ctl(input logic r, input logic e, input logic er, input logic ee);
        ctl_wr = 1'b1;
        wr_rom = r;
        wr_ext = e;
        @(negedge clk);
        ctl_wr = 1'b0;
        chk("rom_en", {31'h0, er}, {31'h0, rom_en});
        chk("ext_en", {31'h0, ee}, {31'h0, ext_en});
    endtask

    task automatic lane(input logic [31:0] d, input logic [1:0] s, input logic f,
                        input logic [31:0] exp);
        acc_rdata = d;
        acc_size = s;
        acc_fetch = f;
        @(negedge clk);
        chk("lanes", exp, acc_data);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        boot(2'h1, 1'b0, 1'b1, 1'b0, BMS_SERIAL_ENTRY);
        boot(2'h2, 1'b1, 1'b1, 1'b1, BMS_UBOOT_VECTOR);
        boot(2'h0, 1'b0, 1'b0, 1'b0, 32'h0);
        boot(2'h3, 1'b1, 1'b1, 1'b1, BMS_RESET_VECTOR);
        lane(32'h11223344, BMS_SZ_WORD, 1'b0, 32'h44332211);
        lane(32'h11223344, BMS_SZ_HALF, 1'b0, 32'h11224433);
        lane(32'h11223344, BMS_SZ_BYTE, 1'b0, 32'h11223344);
        lane(32'h11223344, BMS_SZ_WORD, 1'b1, 32'h11223344);
        access(BMS_LDR_BASE, 1'b0, 1'b0);
        access(BMS_SERIAL_ENTRY + 32'h4, 1'b1, 1'b0);
        access(BMS_UBOOT_BASE, 1'b0, 1'b1);
        access(BMS_UBOOT_BASE + BMS_UBOOT_SIZE - 32'h4, 1'b0, 1'b1);
        access(BMS_ROM_BASE, 1'b1, 1'b1);
        access(BMS_EXT_BASE, 1'b0, 1'b0);
        ctl(1'b1, 1'b1, 1'b1, 1'b1);
        access(BMS_EXT_LIMIT - 32'h4, 1'b0, 1'b1);
        ctl(1'b0, 1'b1, 1'b0, 1'b1);
        access(BMS_ROM_BASE, 1'b1, 1'b0);
        access(BMS_UBOOT_BASE, 1'b0, 1'b0);
        access(BMS_EXT_BASE, 1'b0, 1'b1);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        access(BMS_ROM_BASE, 1'b0, 1'b0);
        boot(2'h3, 1'b0, 1'b1, 1'b1, BMS_RESET_VECTOR);
        access(BMS_ROM_BASE, 1'b0, 1'b1);
        lane(32'hA1B2C3D4, BMS_SZ_WORD, 1'b0, 32'hA1B2C3D4);
        lane(32'hA1B2C3D4, BMS_SZ_HALF, 1'b0, 32'hA1B2C3D4);
        test_done();
    end
endmodule
